/* dv/cgcr_assertions.sv */
// Port-level checks of the configuration bank
`timescale 1ns/1ns
module cgcr_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Observed ports
    input wire logic sclIn,
    input wire logic sdaOe,
    input wire logic [3:0] diffEnable,
    input wire logic [1:0] stopState,
    input wire cgcr_pkg::cgcr_analog_t analogCfg,
    input wire cgcr_pkg::cgcr_drive_t [3:0] diffDrive,
    input wire cgcr_pkg::cgcr_drive_t refDrive
);
    import cgcr_pkg::*;
    // ----
    // Properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Drive outputs lag their causes by one edge, so the past stop field applies
    sequence s_refStop; !$past(rst) && !refDrive.run; endsequence
    sequence s_difStop; !$past(rst) && !diffDrive[0].run; endsequence
    property p_rstVals;
        $fell(rst) |-> analogCfg.amplitude == AMP_0P75 && analogCfg.edgeFast == 4'hf
            && analogCfg.refEdgeSpeed == REFSLEW_2P4;
    endproperty
    a_rstVals: assert property (p_rstVals) else $error("bad value after reset");
    property p_ackLow; $rose(sdaOe) |-> !sclIn; endproperty
    a_ackLow: assert property (p_ackLow) else $error("data pulled while clock high");
    property p_difGate; !$past(diffEnable[0]) |-> !diffDrive[0].run; endproperty
    a_difGate: assert property (p_difGate) else $error("output ran while disabled");
    property p_difHiz; s_difStop ##0 $past(stopState) == STOP_HIZ |-> !diffDrive[0].driveEn;
    endproperty
    a_difHiz: assert property (p_difHiz) else $error("stopped output not floated");
    property p_difHigh;
        s_difStop ##0 $past(stopState) == STOP_HIGHLOW |-> diffDrive[0].trueLvl
            && !diffDrive[0].compLvl;
    endproperty
    a_difHigh: assert property (p_difHigh) else $error("stopped output level wrong");
    property p_refHigh;
        s_refStop ##0 $past(stopState) == STOP_LOWHIGH |-> refDrive.trueLvl && refDrive.driveEn;
    endproperty
    a_refHigh: assert property (p_refHigh) else $error("reference not parked high");
    property p_refLow;
        s_refStop ##0 !$past(stopState[0]) |-> !refDrive.trueLvl && refDrive.driveEn;
    endproperty
    a_refLow: assert property (p_refLow) else $error("reference not parked low");
    property p_refHiz; s_refStop ##0 $past(stopState) == STOP_HIZ |-> !refDrive.driveEn;
    endproperty
    a_refHiz: assert property (p_refHiz) else $error("reference not floated");
endmodule
bind clock_gen_config_regs cgcr_assertions u_cgcr_assertions (.ref_clk(ref_clk), .rst(rst),
    .sclIn(sclIn), .sdaOe(sdaOe), .diffEnable(diffEnable), .stopState(stopState),
    .analogCfg(analogCfg), .diffDrive(diffDrive), .refDrive(refDrive));

/* dv/cgcr_smb_host.sv */
// Management bus host model
`timescale 1ns/1ns
module cgcr_smb_host (
    // Clock and strap
    input wire logic ref_clk,
    input wire logic sadr,
    // Bus lines, data pulled up outside
    input wire logic sda,
    output logic scl,
    output logic sdaPull
);
    import cgcr_pkg::*;
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Levels held 8 cycles, data moved mid-low so the pin syncs never race
    task automatic bx(input logic b, output logic r);
        sdaPull = !b;
        w(4);
        scl = 1'b1;
        w(8);
        r = sda;
        scl = 1'b0;
        w(4);
    endtask
    task automatic st();
        sdaPull = 1'b0;
        w(4);
        scl = 1'b1;
        w(8);
        sdaPull = 1'b1;
        w(8);
        scl = 1'b0;
        w(4);
    endtask
    task automatic xb(input logic [7:0] d, input logic h, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
        bx(h, a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [3:0] k);
        logic [7:0] r;
        st();
        xb({SMB_ADDR_HI, sadr, SMB_ADDR_LO, 1'b0}, 1'b1, r, k[3]);
        xb(a, 1'b1, r, k[2]);
        xb(8'h01, 1'b1, r, k[1]);
        xb(d, 1'b1, r, k[0]);
        sdaPull = 1'b1;
        w(4);
        scl = 1'b1;
        w(8);
        sdaPull = 1'b0;
        w(8);
    endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench of the configuration bank
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import cgcr_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, powerDownN = 1'b1, sdaOut, sdaOe, scl, sdaPull;
    logic [3:0] outEnableN = 4'h0, diffEnable = 4'hf, k;
    logic [1:0] stopState = 2'h3;
    logic [7:0] q;
    cgcr_analog_t cfg;
    cgcr_drive_t [3:0] dd;
    cgcr_drive_t rd;
    cgcr_tri_t strap = TRI_HIGH;
    int bad_count = 0, tests_run = 0, cyc = 0;
    wire logic sda = !(sdaPull || (sdaOe && !sdaOut));
    clock_gen_config_regs #(.REVISION_CODE(4'h6), .VENDOR_CODE(4'h9)) u_clock_gen_config_regs (
        .ref_clk(ref_clk), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .sadrPin(1'b1), .spreadSelPin(strap), .powerDownN(powerDownN),
        .outEnableN(outEnableN), .diffEnable(diffEnable), .stopState(stopState),
        .analogCfg(cfg), .diffDrive(dd), .refDrive(rd));
    cgcr_smb_host u_cgcr_smb_host (.ref_clk(ref_clk), .sadr(1'b1), .sda(sda), .scl(scl),
        .sdaPull(sdaPull));
    initial forever #5 ref_clk = !ref_clk;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_cgcr_smb_host.wr(a, d, k);
        `CHK(k, 4'h0)
    endtask
    // Read: write header, repeated start, fixed count byte, one data byte
    task automatic rb(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] c;
        logic [2:0] m;
        u_cgcr_smb_host.st();
        u_cgcr_smb_host.xb({SMB_ADDR_HI, 3'h4}, 1'b1, c, m[2]);
        u_cgcr_smb_host.xb(a, 1'b1, c, m[1]);
        u_cgcr_smb_host.st();
        u_cgcr_smb_host.xb({SMB_ADDR_HI, 3'h5}, 1'b1, c, m[0]);
        u_cgcr_smb_host.xb(8'hff, 1'b0, c, k[0]);
        u_cgcr_smb_host.xb(8'hff, 1'b1, q, k[0]);
        u_cgcr_smb_host.wr(8'h00, 8'h00, k);
        `CHK({m, c, q}, {3'h0, SMB_BYTE_COUNT, e})
    endtask
    task automatic rsys();
        rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        rsys();
        `CHK({cfg.spread, dd[3].run, dd[0].run}, {SPREAD_HALF, 2'b11})
        rb(8'h01, 8'hc6);
        rb(8'h02, 8'hff);
        rb(8'h03, 8'h5f);
        wr(8'h01, 8'h19);
        `CHK({cfg.spread, cfg.amplitude}, {SPREAD_HALF, AMP_0P68})
        wr(8'h01, 8'h2b);
        `CHK({cfg.spread, cfg.amplitude}, {SPREAD_QUARTER, AMP_0P85})
        wr(8'h01, 8'h20);
        `CHK({cfg.spread, cfg.amplitude}, {SPREAD_OFF, AMP_0P60})
        wr(8'h01, 8'h33);
        `CHK(cfg.spread, SPREAD_OFF)
        strap = TRI_LOW;
        rsys();
        rb(8'h01, 8'h06);
        wr(8'h02, 8'h00);
        rb(8'h02, 8'h95);
        wr(8'h02, 8'h48);
        `CHK(cfg.edgeFast, 4'ha)
        wr(8'h02, 8'h22);
        `CHK(cfg.edgeFast, 4'h5)
        wr(8'h03, 8'h00);
        rb(8'h03, 8'h0f);
        `CHK({cfg.refEdgeSpeed, rd.run, rd.trueLvl}, {REFSLEW_1P4, 2'b01})
        diffEnable = 4'ha;
        for (int s = 0; s < 4; s++) begin
            stopState = 2'(s);
            repeat (4) @(posedge ref_clk) #1;
            `CHK({dd[3].run, dd[2].run, dd[1].run, dd[0].run}, 4'ha)
            `CHK({dd[0][2:0], rd}, {s == 2, s == 3, s != 1, 1'b0, s == 3, 1'b0, s != 1})
        end
        powerDownN = 1'b0;
        wr(8'h03, 8'hb0);
        `CHK({cfg.refEdgeSpeed, rd.run}, {REFSLEW_3P0, 1'b1})
        wr(8'h03, 8'hd0);
        `CHK({cfg.refEdgeSpeed, rd.run}, {REFSLEW_3P2, 1'b0})
        powerDownN = 1'b1;
        repeat (6) @(posedge ref_clk);
        `CHK(rd.run, 1'b1)
        wr(8'h05, 8'h00);
        rb(8'h05, 8'h69);
        wr(8'h04, 8'h00);
        rb(8'h04, 8'h40);
        rb(8'h0a, 8'h00);
        report_and_stop();
    end
endmodule

/* hw/cgcr_out_ctrl.sv */
// Run/stop drive control of the four differential outputs and the reference output
`timescale 1ns/1ns
module cgcr_out_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Controls
    input wire logic [3:0] diffEnable,
    input wire logic [3:0] oeSyncN,
    input wire logic pdSyncN,
    input wire logic refEnable,
    input wire logic refKeepAlive,
    input wire logic [1:0] stopState,
    // Drive results
    output cgcr_pkg::cgcr_drive_t [3:0] diffDrive,
    output cgcr_pkg::cgcr_drive_t refDrive
);
    import cgcr_pkg::*;

    typedef struct packed {
        cgcr_drive_t [3:0] diff;
        cgcr_drive_t refCk;
    } cgcr_drv_state_t;

    cgcr_drv_state_t st;
    cgcr_drv_state_t next_st;

    always_comb begin
        next_st = st;
        for (int i = 0; i < 4; i++) begin
            // Cleared enable bit overrides the pin; set bit hands control to the pin
            next_st.diff[i].run = diffEnable[i] & ~oeSyncN[i];
            next_st.diff[i].driveEn = 1'b1;
            next_st.diff[i].trueLvl = 1'b0;
            next_st.diff[i].compLvl = 1'b0;
            if (!next_st.diff[i].run) begin
                case (stopState)
                    STOP_HIZ: begin
                        next_st.diff[i].driveEn = 1'b0;
                    end
                    STOP_HIGHLOW: begin
                        next_st.diff[i].trueLvl = 1'b1;
                    end
                    STOP_LOWHIGH: begin
                        next_st.diff[i].compLvl = 1'b1;
                    end
                    default: begin
                        next_st.diff[i].trueLvl = 1'b0;
                    end
                endcase
            end
        end
        next_st.refCk.run = refEnable & (pdSyncN | refKeepAlive);
        next_st.refCk.driveEn = 1'b1;
        next_st.refCk.trueLvl = 1'b0;
        next_st.refCk.compLvl = 1'b0;
        if (!next_st.refCk.run) begin
            next_st.refCk.driveEn = (stopState != STOP_HIZ);
            next_st.refCk.trueLvl = (stopState == STOP_LOWHIGH);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign diffDrive = st.diff;
    assign refDrive = st.refCk;

endmodule

/* hw/cgcr_pin_sync.sv */
// Two-stage synchronisers and start/stop/edge detection for the device pins
`timescale 1ns/1ns
module cgcr_pin_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Raw pins
    input wire logic sclPin,
    input wire logic sdaPin,
    input wire cgcr_pkg::cgcr_pins_t rawPins,
    // Synchronised results
    output cgcr_pkg::cgcr_smb_ev_t busEv,
    output cgcr_pkg::cgcr_pins_t syncPins
);
    import cgcr_pkg::*;

    typedef struct packed {
        logic [1:0] busMeta;
        logic [1:0] busSync;
        logic [1:0] busPrev;
        cgcr_pins_t pinMeta;
        cgcr_pins_t pinSync;
    } cgcr_sync_state_t;

    cgcr_sync_state_t st;
    cgcr_sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.busMeta = {sclPin, sdaPin};
        next_st.busSync = st.busMeta;
        next_st.busPrev = st.busSync;
        next_st.pinMeta = rawPins;
        next_st.pinSync = st.pinMeta;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '{busMeta: 2'h3, busSync: 2'h3, busPrev: 2'h3,
                    pinMeta: '{sadr: 1'b0, spreadTri: TRI_LOW, pdN: 1'b1, oeN: 4'h0},
                    pinSync: '{sadr: 1'b0, spreadTri: TRI_LOW, pdN: 1'b1, oeN: 4'h0}};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Events look only at the second stage and its delayed copy
    // ------------------------------------------------------------------
    always_comb begin
        busEv.sda = st.busSync[0];
        busEv.sclRise = st.busSync[1] & ~st.busPrev[1];
        busEv.sclFall = ~st.busSync[1] & st.busPrev[1];
        busEv.start = st.busSync[1] & st.busPrev[1] & st.busPrev[0] & ~st.busSync[0];
        busEv.stop = st.busSync[1] & st.busPrev[1] & ~st.busPrev[0] & st.busSync[0];
    end

    assign syncPins = st.pinSync;

endmodule

/* hw/clock_gen_config_regs.sv */
// Configuration register bank (bytes 1 to 5) with its management-bus slave
`timescale 1ns/1ns
module clock_gen_config_regs #(
    // Identification nibbles, values arbitrary
    parameter logic [3:0] REVISION_CODE = 4'ha,
    parameter logic [3:0] VENDOR_CODE = 4'h5
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Management bus pins (open drain data)
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Strap and control pins
    input wire logic sadrPin,
    input wire cgcr_pkg::cgcr_tri_t spreadSelPin,
    input wire logic powerDownN,
    input wire logic [3:0] outEnableN,
    // Settings held by the neighbouring output-enable and stop bytes
    input wire logic [3:0] diffEnable,
    input wire logic [1:0] stopState,
    // Settings to the analog core
    output cgcr_pkg::cgcr_analog_t analogCfg,
    output cgcr_pkg::cgcr_drive_t [3:0] diffDrive,
    output cgcr_pkg::cgcr_drive_t refDrive
);
    import cgcr_pkg::*;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        S_IDLE = 9'b0_0000_0001,
        S_ADDR = 9'b0_0000_0010,
        S_ADDR_ACK = 9'b0_0000_0100,
        S_CMD = 9'b0_0000_1000,
        S_CMD_ACK = 9'b0_0001_0000,
        S_WDATA = 9'b0_0010_0000,
        S_WDATA_ACK = 9'b0_0100_0000,
        S_TX = 9'b0_1000_0000,
        S_TX_ACK = 9'b1_0000_0000
    } cgcr_fsm_t;

    typedef struct packed {
        cgcr_fsm_t fsm;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [3:0] bitCnt;
        logic [7:0] ptr;
        logic cmdSeen;
        logic gotCount;
        logic hostAck;
        logic sdaDrive;
        logic strapTaken;
        logic [1:0] settle;
        logic sadr;
        logic [1:0] readback;
        logic [7:0] spreadReg;
        logic [7:0] slewReg;
        logic [7:0] refReg;
        cgcr_analog_t analog;
    } cgcr_state_t;

    cgcr_state_t st;
    cgcr_state_t next_st;
    cgcr_smb_ev_t ev;
    cgcr_pins_t rawPins;
    cgcr_pins_t syncPins;

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    assign rawPins = '{sadr: sadrPin, spreadTri: spreadSelPin, pdN: powerDownN,
                       oeN: outEnableN};

    cgcr_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .sclPin(sclIn),
        .sdaPin(sdaIn),
        .rawPins(rawPins),
        .busEv(ev),
        .syncPins(syncPins)
    );

    // ------------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------------
    function automatic logic [7:0] readReg(input cgcr_state_t s, input logic [7:0] addr);
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            REG_SPREAD: begin
                value = (s.spreadReg & WMASK_SPREAD) | (RST_SPREAD & ~WMASK_SPREAD);
                value[SPREAD_RB_LSB +: 2] = s.readback;
            end
            REG_SLEW: begin
                value = (s.slewReg & WMASK_SLEW) | (RST_SLEW & ~WMASK_SLEW);
            end
            REG_REF: begin
                value = (s.refReg & WMASK_REF) | (RST_REF & ~WMASK_REF);
            end
            REG_RSVD4: begin
                value = RST_RSVD4;
            end
            REG_IDENT: begin
                value = {REVISION_CODE, VENDOR_CODE};
            end
            default: begin
                value = 8'h00;
            end
        endcase
        return value;
    endfunction

    function automatic cgcr_spread_t decodeSpread(input logic [1:0] code);
        cgcr_spread_t amount;
        case (code)
            2'b01: begin
                amount = SPREAD_QUARTER;
            end
            2'b11: begin
                amount = SPREAD_HALF;
            end
            default: begin
                amount = SPREAD_OFF;
            end
        endcase
        return amount;
    endfunction

    // ------------------------------------------------------------------
    // Bus slave and register update
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] rxNext;
        logic addrMatch;
        rxNext = {st.rx[6:0], ev.sda};
        addrMatch = (st.rx[7:3] == SMB_ADDR_HI) && (st.rx[2] == st.sadr)
                    && (st.rx[1] == SMB_ADDR_LO);
        next_st = st;

        // Strap levels caught once the syncs settle
        next_st.settle = {st.settle[0], 1'b1};
        if (!st.strapTaken && st.settle[1]) begin
            next_st.strapTaken = 1'b1;
            next_st.sadr = syncPins.sadr;
            case (syncPins.spreadTri)
                TRI_MID: begin
                    next_st.readback = RB_MID;
                end
                TRI_HIGH: begin
                    next_st.readback = RB_HIGH;
                end
                default: begin
                    next_st.readback = RB_LOW;
                end
            endcase
        end

        case (st.fsm)
            S_ADDR, S_CMD, S_WDATA: begin
                if (ev.sclRise && st.bitCnt < BITS_PER_BYTE) begin
                    next_st.rx = rxNext;
                    next_st.bitCnt = st.bitCnt + 4'h1;
                end else if (ev.sclFall && st.bitCnt == BITS_PER_BYTE) begin
                    next_st.bitCnt = 4'h0;
                    if (st.fsm == S_ADDR) begin
                        if (addrMatch && (!st.rx[0] || st.cmdSeen)) begin
                            next_st.fsm = S_ADDR_ACK;
                            next_st.sdaDrive = 1'b1;
                        end else begin
                            next_st.fsm = S_IDLE;
                        end
                    end else if (st.fsm == S_CMD) begin
                        next_st.ptr = st.rx;
                        next_st.cmdSeen = 1'b1;
                        next_st.fsm = S_CMD_ACK;
                        next_st.sdaDrive = 1'b1;
                    end else begin
                        next_st.fsm = S_WDATA_ACK;
                        next_st.sdaDrive = 1'b1;
                        if (!st.gotCount) begin
                            next_st.gotCount = 1'b1;
                        end else begin
                            case (st.ptr)
                                REG_SPREAD: begin
                                    next_st.spreadReg = st.rx & WMASK_SPREAD;
                                end
                                REG_SLEW: begin
                                    next_st.slewReg = st.rx & WMASK_SLEW;
                                end
                                REG_REF: begin
                                    next_st.refReg = st.rx & WMASK_REF;
                                end
                                default: begin
                                    next_st.ptr = st.ptr;
                                end
                            endcase
                            next_st.ptr = st.ptr + 8'h01;
                        end
                    end
                end
            end
            S_ADDR_ACK: begin
                if (ev.sclFall) begin
                    if (st.rx[0]) begin
                        next_st.fsm = S_TX;
                        next_st.tx = SMB_BYTE_COUNT;
                        next_st.sdaDrive = ~SMB_BYTE_COUNT[7];
                    end else begin
                        next_st.fsm = S_CMD;
                        next_st.sdaDrive = 1'b0;
                    end
                end
            end
            S_CMD_ACK: begin
                if (ev.sclFall) begin
                    next_st.fsm = S_WDATA;
                    next_st.gotCount = 1'b0;
                    next_st.sdaDrive = 1'b0;
                end
            end
            S_WDATA_ACK: begin
                if (ev.sclFall) begin
                    next_st.fsm = S_WDATA;
                    next_st.sdaDrive = 1'b0;
                end
            end
            S_TX: begin
                if (ev.sclFall) begin
                    if (st.bitCnt == BITS_PER_BYTE - 4'h1) begin
                        next_st.bitCnt = 4'h0;
                        next_st.fsm = S_TX_ACK;
                        next_st.sdaDrive = 1'b0;
                    end else begin
                        next_st.bitCnt = st.bitCnt + 4'h1;
                        next_st.tx = {st.tx[6:0], 1'b0};
                        next_st.sdaDrive = ~st.tx[6];
                    end
                end
            end
            S_TX_ACK: begin
                if (ev.sclRise) begin
                    next_st.hostAck = ~ev.sda;
                end else if (ev.sclFall) begin
                    if (st.hostAck) begin
                        next_st.tx = readReg(st, st.ptr);
                        next_st.sdaDrive = ~next_st.tx[7];
                        next_st.ptr = st.ptr + 8'h01;
                        next_st.fsm = S_TX;
                    end else begin
                        next_st.fsm = S_IDLE;
                    end
                end
            end
            default: begin
                next_st.fsm = S_IDLE;
                next_st.sdaDrive = 1'b0;
            end
        endcase

        // Start and stop override any phase; a repeated start keeps the pointer
        if (ev.stop) begin
            next_st.fsm = S_IDLE;
            next_st.sdaDrive = 1'b0;
            next_st.cmdSeen = 1'b0;
        end else if (ev.start) begin
            next_st.fsm = S_ADDR;
            next_st.bitCnt = 4'h0;
            next_st.sdaDrive = 1'b0;
        end

        // ------------------------------------------------------------------
        // Analog settings; registered so that the core sees glitch-free levels
        // ------------------------------------------------------------------
        // Software code only steers spread while the select bit is set
        if (st.spreadReg[SPREAD_SW_SEL]) begin
            next_st.analog.spread = decodeSpread(st.spreadReg[SPREAD_SW_LSB +: 2]);
        end else begin
            next_st.analog.spread = decodeSpread(st.readback);
        end
        next_st.analog.amplitude = cgcr_amp_t'(st.spreadReg[AMP_LSB +: 2]);
        for (int i = 0; i < 4; i++) begin
            next_st.analog.edgeFast[i] = st.slewReg[EDGE_BIT[i]];
        end
        next_st.analog.refEdgeSpeed = cgcr_refslew_t'(st.refReg[REF_SLEW_LSB +: 2]);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '{fsm: S_IDLE, rx: 8'h00, tx: 8'h00, bitCnt: 4'h0, ptr: 8'h00,
                    cmdSeen: 1'b0, gotCount: 1'b0, hostAck: 1'b0, sdaDrive: 1'b0,
                    strapTaken: 1'b0, settle: 2'h0, sadr: 1'b0, readback: RB_LOW,
                    spreadReg: RST_SPREAD & WMASK_SPREAD,
                    slewReg: RST_SLEW & WMASK_SLEW,
                    refReg: RST_REF & WMASK_REF,
                    analog: '{spread: SPREAD_OFF, amplitude: AMP_0P75,
                              edgeFast: 4'hf, refEdgeSpeed: REFSLEW_2P4}};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Output drive control
    // ------------------------------------------------------------------
    cgcr_out_ctrl u_out (
        .ref_clk(ref_clk),
        .rst(rst),
        .diffEnable(diffEnable),
        .oeSyncN(syncPins.oeN),
        .pdSyncN(syncPins.pdN),
        .refEnable(st.refReg[REF_OE_BIT]),
        .refKeepAlive(st.refReg[REF_KEEP_BIT]),
        .stopState(stopState),
        .diffDrive(diffDrive),
        .refDrive(refDrive)
    );

    // Open drain: only ever pull low
    assign sdaOut = 1'b0;
    assign sdaOe = st.sdaDrive;
    assign analogCfg = st.analog;

endmodule

/* include/cgcr_pkg.sv */
// Constants, encodings and carrier types of the clock generator configuration bank
package cgcr_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte locations on the management bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_SPREAD = 8'h01;
    localparam logic [7:0] REG_SLEW = 8'h02;
    localparam logic [7:0] REG_REF = 8'h03;
    localparam logic [7:0] REG_RSVD4 = 8'h04;
    localparam logic [7:0] REG_IDENT = 8'h05;

    // ------------------------------------------------------------------
    // Values after reset and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_SPREAD = 8'h06;
    localparam logic [7:0] RST_SLEW = 8'hff;
    localparam logic [7:0] RST_REF = 8'h5f;
    localparam logic [7:0] RST_RSVD4 = 8'h40;
    localparam logic [7:0] WMASK_SPREAD = 8'h3b;
    localparam logic [7:0] WMASK_SLEW = 8'h6a;
    localparam logic [7:0] WMASK_REF = 8'hf0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SPREAD_RB_LSB = 6;
    localparam int SPREAD_SW_SEL = 5;
    localparam int SPREAD_SW_LSB = 3;
    localparam int AMP_LSB = 0;
    localparam int REF_SLEW_LSB = 6;
    localparam int REF_KEEP_BIT = 5;
    localparam int REF_OE_BIT = 4;
    localparam int EDGE_BIT [0:3] = '{1, 3, 5, 6};

    // ------------------------------------------------------------------
    // Management bus constants
    // ------------------------------------------------------------------
    localparam logic [4:0] SMB_ADDR_HI = 5'h1a;
    localparam logic SMB_ADDR_LO = 1'b0;
    localparam logic [7:0] SMB_BYTE_COUNT = 8'h08;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TRI_LOW = 2'b00,
        TRI_MID = 2'b01,
        TRI_HIGH = 2'b10
    } cgcr_tri_t;

    localparam logic [1:0] RB_LOW = 2'b00;
    localparam logic [1:0] RB_MID = 2'b10;
    localparam logic [1:0] RB_HIGH = 2'b11;

    typedef enum logic [1:0] {
        SPREAD_OFF = 2'b00,
        SPREAD_QUARTER = 2'b01,
        SPREAD_HALF = 2'b10
    } cgcr_spread_t;

    typedef enum logic [1:0] {
        AMP_0P60 = 2'b00,
        AMP_0P68 = 2'b01,
        AMP_0P75 = 2'b10,
        AMP_0P85 = 2'b11
    } cgcr_amp_t;

    typedef enum logic [1:0] {
        REFSLEW_1P4 = 2'b00,
        REFSLEW_2P4 = 2'b01,
        REFSLEW_3P0 = 2'b10,
        REFSLEW_3P2 = 2'b11
    } cgcr_refslew_t;

    localparam logic [1:0] STOP_LOWLOW = 2'b00;
    localparam logic [1:0] STOP_HIZ = 2'b01;
    localparam logic [1:0] STOP_HIGHLOW = 2'b10;
    localparam logic [1:0] STOP_LOWHIGH = 2'b11;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic stop;
        logic sclRise;
        logic sclFall;
        logic sda;
    } cgcr_smb_ev_t;

    typedef struct packed {
        logic sadr;
        cgcr_tri_t spreadTri;
        logic pdN;
        logic [3:0] oeN;
    } cgcr_pins_t;

    typedef struct packed {
        logic run;
        logic trueLvl;
        logic compLvl;
        logic driveEn;
    } cgcr_drive_t;

    typedef struct packed {
        cgcr_spread_t spread;
        cgcr_amp_t amplitude;
        logic [3:0] edgeFast;
        cgcr_refslew_t refEdgeSpeed;
    } cgcr_analog_t;

endpackage
